// >>> src/rtcsp_dev.sv
// Slave end of the two-wire port: address match, pointer, byte store.
// Assumes the clock pin toggles far slower than i_sys_clk (see sync delay).
`timescale 1ns/100ps
module rtcsp_dev
  import rtcsp_pkg::*;
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  rtcsp_if.dev                         bus,
  input  wire logic [TIME_N-1:0][7:0]  i_time,
  output logic                         o_wr_valid,
  output logic      [PTR_W-1:0]        o_wr_addr,
  output logic      [7:0]              o_wr_data,
  output logic                         o_busy
);

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_TACK
  } rtcsp_dst_e;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} rtcsp_kind_e;

  logic                  scl_m_r, scl_s_r, scl_d_r;
  logic                  sda_m_r, sda_s_r, sda_d_r;
  logic                  scl_rise, scl_fall, start_det, stop_det;
  rtcsp_dst_e            st_r, st_nxt;
  rtcsp_kind_e           kind_r, kind_nxt;
  logic [3:0]            cnt_r, cnt_nxt;
  logic [7:0]            sh_r, sh_nxt;
  logic                  rw_r, rw_nxt;
  logic [PTR_W-1:0]      ptr_r, ptr_nxt;
  logic                  oe_r, oe_nxt;
  logic                  mack_r, mack_nxt;
  logic [TIME_N-1:0][7:0] shadow_r, shadow_nxt;
  logic                  wr_valid_nxt;
  logic [PTR_W-1:0]      wr_addr_nxt;
  logic [7:0]            wr_data_nxt;
  logic                  mem_we;
  logic [7:0]            rd_byte;
  logic [7:0]            mem [0:(1<<PTR_W)-1];

  // Pin synchronisers; only the second stage and its delay feed logic
  // Oversampling at i_sys_clk covers both standard and fast link rates
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= bus.scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= bus.sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Bus condition decode from the settled copies
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // Time bytes come from the snapshot so a read never sees a carry ripple
  assign rd_byte = (ptr_r < TIME_END) ? shadow_r[ptr_r[2:0]]
                                      : mem[ptr_r];

  // Protocol engine; the slave never drives the clock
  always_comb begin
    st_nxt       = st_r;
    kind_nxt     = kind_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    rw_nxt       = rw_r;
    ptr_nxt      = ptr_r;
    oe_nxt       = oe_r;
    mack_nxt     = mack_r;
    shadow_nxt   = shadow_r;
    wr_valid_nxt = 1'b0;
    wr_addr_nxt  = o_wr_addr;
    wr_data_nxt  = o_wr_data;
    mem_we       = 1'b0;
    if (stop_det) begin
      st_nxt = DS_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      // A repeated START lands here too, from any state
      st_nxt     = DS_RX;
      kind_nxt   = K_ADDR;
      cnt_nxt    = 4'h0;
      oe_nxt     = 1'b0;
      shadow_nxt = i_time;
    end else begin
      unique case (st_r)
        DS_IDLE: begin
          oe_nxt = 1'b0;
        end
        DS_RX: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt = 4'h0;
            st_nxt  = DS_ACK;
            oe_nxt  = 1'b1;
            unique case (kind_r)
              K_ADDR: begin
                if (sh_r[7:1] != SLV_ADDR) begin
                  st_nxt = DS_IDLE;
                  oe_nxt = 1'b0;
                end else begin
                  rw_nxt = sh_r[0];
                end
              end
              K_PTR: begin
                ptr_nxt = sh_r[PTR_W-1:0];
              end
              K_DATA: begin
                mem_we       = 1'b1;
                wr_valid_nxt = 1'b1;
                wr_addr_nxt  = ptr_r;
                wr_data_nxt  = sh_r;
                ptr_nxt      = ptr_r + 1'b1;
              end
            endcase
          end
        end
        DS_ACK: begin
          // Release on the falling edge so data changes while clock is low
          if (scl_fall) begin
            if (kind_r == K_ADDR && rw_r) begin
              st_nxt = DS_TX;
              sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
            end else begin
              st_nxt   = DS_RX;
              oe_nxt   = 1'b0;
              kind_nxt = (kind_r == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS - 4'h1) begin
              st_nxt  = DS_TACK;
              oe_nxt  = 1'b0;
              cnt_nxt = 4'h0;
              ptr_nxt = ptr_r + 1'b1;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        DS_TACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_s_r;
          end else if (scl_fall) begin
            if (mack_r) begin
              st_nxt = DS_TX;
              sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
            end else begin
              st_nxt = DS_IDLE;
              oe_nxt = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r       <= DS_IDLE;
      kind_r     <= K_ADDR;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      rw_r       <= 1'b0;
      ptr_r      <= '0;
      oe_r       <= 1'b0;
      mack_r     <= 1'b0;
      shadow_r   <= '0;
      o_wr_valid <= 1'b0;
      o_wr_addr  <= '0;
      o_wr_data  <= 8'h00;
    end else begin
      st_r       <= st_nxt;
      kind_r     <= kind_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      rw_r       <= rw_nxt;
      ptr_r      <= ptr_nxt;
      oe_r       <= oe_nxt;
      mack_r     <= mack_nxt;
      shadow_r   <= shadow_nxt;
      o_wr_valid <= wr_valid_nxt;
      o_wr_addr  <= wr_addr_nxt;
      o_wr_data  <= wr_data_nxt;
    end
  end

  // Byte store; contents are data, so no reset is spent on them
  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      mem[ptr_r] <= sh_r;
    end
  end

  // Open drain: only ever pulls low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_r;
  assign o_busy         = (st_r != DS_IDLE);

endmodule : rtcsp_dev

// >>> src/rtcsp_if.sv
// Two-wire link between master and slave port.
// Clock is push-pull from the master; data is open drain with pull-up.
`timescale 1ns/100ps
interface rtcsp_if;
  logic scl;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with the pull-up: any enabled low driver wins
  assign sda = ~((mst_sda_oe & ~mst_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport mst (output scl, output mst_sda_o, output mst_sda_oe, input sda);
endinterface : rtcsp_if

// >>> src/rtcsp_mst.sv
// Master end: makes the clock by division and runs one command at a time.
// Assumes the slave never stretches the clock.
`timescale 1ns/100ps
module rtcsp_mst
  import rtcsp_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
)(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  rtcsp_if.mst             bus,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire logic        i_cmd_rd,
  input  wire logic        i_cmd_setp,
  input  wire logic [7:0]  i_cmd_ptr,
  input  wire logic [7:0]  i_cmd_len,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wdata_valid,
  output logic             o_wdata_ready,
  output logic      [7:0]  o_rdata,
  output logic             o_rdata_valid,
  output logic             o_done,
  output logic             o_nack
);

  generate
    if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_bad_qtr
      $error("QTR_CYC out of range");
    end
  endgenerate

  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} rtcsp_mst_e;
  typedef enum logic [2:0] {
    P_ADDRW, P_PTR, P_WDATA, P_ADDRR, P_RDATA
  } rtcsp_ph_e;

  logic        sda_m_r, sda_s_r;
  rtcsp_mst_e  st_r, st_nxt;
  rtcsp_ph_e   ph_r, ph_nxt;
  logic [15:0] div_r, div_nxt;
  logic [1:0]  q_r, q_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        scl_r, scl_nxt;
  logic        low_r, low_nxt;
  logic        rd_r, rd_nxt;
  logic [7:0]  ptr_r, ptr_nxt;
  logic [7:0]  rem_r, rem_nxt;
  logic        ack_r, ack_nxt;
  logic        nack_nxt, done_nxt, rvld_nxt;
  logic [7:0]  rdata_nxt;
  logic        tick, byte_end, txing, need_w, go;

  // Data pin synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= bus.sda;
      sda_s_r <= sda_m_r;
    end
  end

  assign tick     = (st_r != MS_IDLE) && (div_r == 16'(QTR_CYC - 1));
  assign byte_end = (st_r == MS_BIT) && (q_r == 2'h3) && (bit_r == BYTE_BITS);
  assign txing    = (ph_r != P_RDATA);
  // Next byte to send is write data; wait for it rather than send garbage
  assign need_w = ~rd_r && ack_r && rem_r != 8'h00 &&
                  (ph_r == P_PTR || ph_r == P_WDATA);
  assign go            = tick && !(byte_end && need_w && !i_wdata_valid);
  assign o_wdata_ready = tick && byte_end && need_w;
  assign o_cmd_ready   = (st_r == MS_IDLE);

  // Quarter-period sequencer; master alone drives clock and conditions
  always_comb begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    div_nxt   = go ? 16'h0000 : (tick ? div_r : div_r + 16'h0001);
    q_nxt     = go ? q_r + 2'h1 : q_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    scl_nxt   = scl_r;
    low_nxt   = low_r;
    rd_nxt    = rd_r;
    ptr_nxt   = ptr_r;
    rem_nxt   = rem_r;
    ack_nxt   = ack_r;
    nack_nxt  = o_nack;
    done_nxt  = 1'b0;
    rvld_nxt  = 1'b0;
    rdata_nxt = o_rdata;
    unique case (st_r)
      MS_IDLE: begin
        div_nxt = 16'h0000;
        q_nxt   = 2'h0;
        if (i_cmd_valid) begin
          st_nxt   = MS_START;
          ph_nxt   = (i_cmd_rd && !i_cmd_setp) ? P_ADDRR : P_ADDRW;
          rd_nxt   = i_cmd_rd;
          ptr_nxt  = i_cmd_ptr;
          rem_nxt  = (i_cmd_rd && i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
          nack_nxt = 1'b0;
        end
      end
      MS_START: if (go) begin
        // Release, raise clock, pull data low, drop clock: START or restart
        unique case (q_r)
          2'h0: low_nxt = 1'b0;
          2'h1: scl_nxt = 1'b1;
          2'h2: low_nxt = 1'b1;
          2'h3: begin
            scl_nxt = 1'b0;
            st_nxt  = MS_BIT;
            bit_nxt = 4'h0;
            sh_nxt  = {SLV_ADDR, ph_r == P_ADDRR};
          end
        endcase
      end
      MS_BIT: if (go) begin
        unique case (q_r)
          2'h0: begin
            if (bit_r != BYTE_BITS) begin
              low_nxt = txing & ~sh_r[7];
            end else begin
              low_nxt = ~txing && rem_r != 8'h01;
            end
          end
          2'h1: scl_nxt = 1'b1;
          2'h2: begin
            if (bit_r != BYTE_BITS && !txing) begin
              sh_nxt = {sh_r[6:0], sda_s_r};
            end else if (bit_r == BYTE_BITS) begin
              ack_nxt = ~sda_s_r;
            end
          end
          2'h3: begin
            scl_nxt = 1'b0;
            if (bit_r != BYTE_BITS) begin
              bit_nxt = bit_r + 4'h1;
              if (txing) begin
                sh_nxt = {sh_r[6:0], 1'b0};
              end
            end else begin
              bit_nxt = 4'h0;
              if (txing && !ack_r) begin
                st_nxt   = MS_STOP;
                nack_nxt = 1'b1;
              end else begin
                unique case (ph_r)
                  P_ADDRW: begin
                    ph_nxt = P_PTR;
                    sh_nxt = ptr_r;
                  end
                  P_PTR, P_WDATA: begin
                    if (rd_r) begin
                      st_nxt = MS_START;
                      ph_nxt = P_ADDRR;
                    end else if (rem_r == 8'h00) begin
                      st_nxt = MS_STOP;
                    end else begin
                      ph_nxt  = P_WDATA;
                      sh_nxt  = i_wdata;
                      rem_nxt = rem_r - 8'h01;
                    end
                  end
                  P_ADDRR: begin
                    ph_nxt = P_RDATA;
                  end
                  P_RDATA: begin
                    rvld_nxt  = 1'b1;
                    rdata_nxt = sh_r;
                    rem_nxt   = rem_r - 8'h01;
                    if (rem_r == 8'h01) begin
                      st_nxt = MS_STOP;
                    end
                  end
                  default: st_nxt = MS_STOP;
                endcase
              end
            end
          end
        endcase
      end
      MS_STOP: if (go) begin
        unique case (q_r)
          2'h0: low_nxt = 1'b1;
          2'h1: scl_nxt = 1'b1;
          2'h2: low_nxt = 1'b0;
          2'h3: begin
            st_nxt   = MS_IDLE;
            done_nxt = 1'b1;
          end
        endcase
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r          <= MS_IDLE;
      ph_r          <= P_ADDRW;
      div_r         <= 16'h0000;
      q_r           <= 2'h0;
      bit_r         <= 4'h0;
      sh_r          <= 8'h00;
      scl_r         <= 1'b1;
      low_r         <= 1'b0;
      rd_r          <= 1'b0;
      ptr_r         <= 8'h00;
      rem_r         <= 8'h00;
      ack_r         <= 1'b0;
      o_nack        <= 1'b0;
      o_done        <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata       <= 8'h00;
    end else begin
      st_r          <= st_nxt;
      ph_r          <= ph_nxt;
      div_r         <= div_nxt;
      q_r           <= q_nxt;
      bit_r         <= bit_nxt;
      sh_r          <= sh_nxt;
      scl_r         <= scl_nxt;
      low_r         <= low_nxt;
      rd_r          <= rd_nxt;
      ptr_r         <= ptr_nxt;
      rem_r         <= rem_nxt;
      ack_r         <= ack_nxt;
      o_nack        <= nack_nxt;
      o_done        <= done_nxt;
      o_rdata_valid <= rvld_nxt;
      o_rdata       <= rdata_nxt;
    end
  end

  assign bus.scl        = scl_r;
  assign bus.mst_sda_o  = 1'b0;
  assign bus.mst_sda_oe = low_r;

endmodule : rtcsp_mst

// >>> src/rtcsp_pkg.sv
// Shared constants for the two-wire clock/RAM slave port and its master.
// Assumes a 250 MHz system clock on both ends and an open-drain data line.
package rtcsp_pkg;
  localparam logic [6:0] SLV_ADDR    = 7'h68;
  localparam int         PTR_W       = 6;
  localparam int         TIME_N      = 7;
  localparam logic [5:0] TIME_END    = 6'h07;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         SYS_CLK_KHZ = 250000;
  localparam int         SCL_MAX_KHZ = 400;
  // Quarter of a clock period, rounded up so the rate never exceeds 400 kHz
  localparam int         SCL_QTR_CYC =
    (SYS_CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
endpackage : rtcsp_pkg

// >>> test/rtc_serial_slave_port_tb_top.sv
// Bench: master end against slave end, plus a bit-banged second link.
// Second link lets the bench send a foreign address to a slave copy.
`timescale 1ns/100ps
module rtc_serial_slave_port_tb_top;
  import rtcsp_pkg::*;
  localparam int Q  = 4;   // Shortest quarter keeps the run brief
  localparam int BQ = 10;  // Bench link clock: 40 cycles = 160 ns
  logic                   i_sys_clk, i_rst_n, cmd_valid, cmd_rd, cmd_setp;
  logic [7:0]             cmd_ptr, cmd_len, rdata, sh;
  logic                   cmd_ready, wdata_ready, rdata_valid, done, nack;
  logic                   wr_valid, wr2_valid, scl_q, sda_q, bs, busy;
  logic [PTR_W-1:0]       wr_addr;
  logic [7:0]             wr_data;
  logic [TIME_N-1:0][7:0] time_v, time_a;
  logic [7:0]             wbuf [8];
  int                     widx, nb, w2n, cyc, errors, tests_run;
  logic [15:0]            rq[$], wq[$], aq[$];
  rtcsp_if bus_a ();
  rtcsp_if bus_b ();

  rtcsp_mst #(.QTR_CYC(Q)) rtcsp_mst_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus(bus_a),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_rd(cmd_rd),
    .i_cmd_setp(cmd_setp), .i_cmd_ptr(cmd_ptr), .i_cmd_len(cmd_len),
    .i_wdata(wbuf[widx]), .i_wdata_valid(1'b1), .o_wdata_ready(wdata_ready),
    .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_done(done),
    .o_nack(nack));
  rtcsp_dev rtcsp_dev_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus(bus_a), .i_time(time_v),
    .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_busy(busy));
  rtcsp_dev rtcsp_dev_i2 (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bus(bus_b), .i_time(time_v),
    .o_wr_valid(wr2_valid), .o_wr_addr(), .o_wr_data(), .o_busy());
  rtcsp_chk #(.QTR(Q)) rtcsp_chk_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .scl(bus_a.scl),
    .sda(bus_a.sda), .mst_sda_oe(bus_a.mst_sda_oe),
    .dev_sda_oe(bus_a.dev_sda_oe));

  // System clock, 4 ns
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // Capture results; live time moves on once a read byte is out
  always @(posedge i_sys_clk) begin
    if (rdata_valid === 1'b1) begin
      rq.push_back({8'h00, rdata});
      time_v <= ~time_a;
    end
    if (wr_valid === 1'b1) wq.push_back({2'h0, wr_addr, wr_data});
    if (wdata_ready === 1'b1) widx <= widx + 1;
    if (wr2_valid === 1'b1) w2n++;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // Wire monitor: first byte after every START, taken at clock rise
  always @(posedge i_sys_clk) begin
    scl_q <= bus_a.scl;
    sda_q <= bus_a.sda;
    if (bus_a.scl && scl_q && sda_q && !bus_a.sda) nb <= 0;
    else if (bus_a.scl && !scl_q && nb < 8) begin
      sh <= {sh[6:0], bus_a.sda};
      nb <= nb + 1;
      if (nb == 7) aq.push_back({8'h00, sh[6:0], bus_a.sda});
    end
  end

  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask : chk_val

  // An empty queue reads as FFFF, which no expected byte matches
  task automatic chk_q(ref logic [15:0] q[$], input logic [15:0] e);
    if (q.size() == 0) chk_val(16'hFFFF, e);
    else chk_val(q.pop_front(), e);
  endtask : chk_q

  // One command on the master port, then a bounded wait for done
  task automatic cmd(input logic rd, input logic sp, input logic [7:0] p,
                     input logic [7:0] n);
    int k;
    rq.delete();
    wq.delete();
    aq.delete();
    @(posedge i_sys_clk);
    cmd_valid <= 1'b1;
    cmd_rd    <= rd;
    cmd_setp  <= sp;
    cmd_ptr   <= p;
    cmd_len   <= n;
    @(posedge i_sys_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (done !== 1'b1 && k < 5000);
    if (k >= 5000) chk_val(16'h0000, 16'h0001);
    // After STOP the master is ready again and the slave has gone idle
    chk_val({14'h0, cmd_ready, busy}, 16'h0002);
  endtask : cmd

  // Bench link bit: data set with clock low, sampled mid-high
  task automatic bb_bit(input logic b);
    bus_b.mst_sda_oe <= ~b;
    repeat (BQ) @(posedge i_sys_clk);
    bus_b.scl <= 1'b1;
    repeat (BQ) @(posedge i_sys_clk);
    bs = bus_b.sda;
    repeat (BQ) @(posedge i_sys_clk);
    bus_b.scl <= 1'b0;
    repeat (BQ) @(posedge i_sys_clk);
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] v, input logic e);
    for (int i = 7; i >= 0; i--) bb_bit(v[i]);
    bb_bit(1'b1);
    chk_val({15'h0000, bs}, {15'h0000, e});
  endtask : bb_byte

  // START from idle when st is 1, else STOP from clock low
  task automatic bb_cond(input logic st);
    bus_b.mst_sda_oe <= 1'b1;
    repeat (BQ) @(posedge i_sys_clk);
    bus_b.scl <= ~st;
    repeat (BQ) @(posedge i_sys_clk);
    bus_b.mst_sda_oe <= st;
    repeat (2 * BQ) @(posedge i_sys_clk);
  endtask : bb_cond

  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    {cmd_valid, cmd_rd, cmd_setp, cmd_ptr, cmd_len} = '0;
    {widx, nb, w2n, cyc, errors, tests_run} = '0;
    {bus_b.scl, bus_b.mst_sda_o, bus_b.mst_sda_oe} = 3'h4;
    wbuf = '{8'hA1, 8'hB2, 8'hC3, 8'h11, 8'h22, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < TIME_N; k++) time_a[k] = 8'h80 ^ (8'h13 * k[7:0]);
    time_v = time_a;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    cmd(1'b0, 1'b0, 8'h3E, 8'h03);
    chk_q(aq, 16'h00D0);
    chk_q(wq, 16'h3EA1);
    chk_q(wq, 16'h3FB2);
    chk_q(wq, 16'h00C3);
    chk_val({15'h0000, nack}, 16'h0000);
    cmd(1'b0, 1'b0, 8'h20, 8'h02);
    chk_q(wq, 16'h2011);
    chk_q(wq, 16'h2122);
    cmd(1'b0, 1'b0, 8'h20, 8'h00);
    chk_val(16'(wq.size()), 16'h0000);
    cmd(1'b1, 1'b0, 8'h00, 8'h02);
    chk_q(aq, 16'h00D1);
    chk_q(rq, 16'h0011);
    chk_q(rq, 16'h0022);
    // Live time was inverted by the reads above, before this START
    cmd(1'b1, 1'b1, 8'h3F, 8'h02);
    chk_q(aq, 16'h00D0);
    chk_q(aq, 16'h00D1);
    chk_q(rq, 16'h00B2);
    chk_q(rq, {8'h00, ~time_a[0]});
    time_v <= time_a;
    cmd(1'b1, 1'b1, 8'h00, 8'h07);
    for (int k = 0; k < TIME_N; k++) begin
      chk_q(rq, {8'h00, time_a[k]});
    end
    chk_val(16'(rq.size()), 16'h0000);
    chk_val({15'h0000, nack}, 16'h0000);
    // Foreign address first, then the own address on the bench link
    for (int f = 0; f < 2; f++) begin
      bb_cond(1'b1);
      bb_byte({SLV_ADDR ^ 7'(f == 0), 1'b0}, f == 0);
      bb_byte(8'h05, f == 0);
      bb_byte(8'h5A, f == 0);
      bb_cond(1'b0);
      chk_val(16'(w2n), 16'(f));
    end
    give_verdict();
  end
endmodule : rtc_serial_slave_port_tb_top

// >>> test/rtcsp_chk.sv
// Link checker: timing of both ends on the clock and data wires.
// Assumes the link it watches always carries the matching address.
`timescale 1ns/100ps
module rtcsp_chk
  import rtcsp_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC
)(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic mst_sda_oe,
  input wire logic dev_sda_oe
);
  logic        scl_r, sda_r, start, stop, rise;
  logic [3:0]  rise_r, rise_nxt;
  logic [15:0] per_r, per_nxt;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Conditions are judged on a settled clock-high cycle
  assign start = scl && scl_r && sda_r && !sda;
  assign stop  = scl && scl_r && !sda_r && sda;
  assign rise  = scl && !scl_r;

  // Rise count since START saturates, so only the first byte is tracked
  always_comb begin
    rise_nxt = rise_r;
    per_nxt  = (per_r == 16'hFFFF) ? per_r : per_r + 16'h0001;
    if (start) rise_nxt = 4'h0;
    else if (rise && rise_r != 4'hF) rise_nxt = rise_r + 4'h1;
    if (rise) per_nxt = 16'h0000;
  end

  // Reset to idle-bus values so nothing is seen before the first START
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
      rise_r <= 4'hF;
      per_r  <= 16'hFFFF;
    end else begin
      scl_r  <= scl;
      sda_r  <= sda;
      rise_r <= rise_nxt;
      per_r  <= per_nxt;
    end
  end

  a_dev_hold_high: assert property (
    scl && scl_r |-> $stable(dev_sda_oe))
    else $error("slave data moved while clock high");
  a_dev_set_late: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 3))
    else $error("slave data changed too close to clock edge");
  a_start_by_master: assert property (
    start |-> mst_sda_oe && !dev_sda_oe)
    else $error("START not made by the master");
  a_clock_rate: assert property (
    rise |-> per_r >= 16'(4 * QTR - 1))
    else $error("clock period too short");
  a_addr_no_drive: assert property (
    scl && scl_r && rise_r >= 4'h1 && rise_r <= 4'h8 |-> !dev_sda_oe)
    else $error("slave drove data during address byte");
  a_addr_ack_low: assert property (
    scl && scl_r && rise_r == 4'h9 |-> !sda && dev_sda_oe)
    else $error("address byte not acknowledged");
  a_stop_idle: assert property (
    stop |=> (scl && sda) [*4])
    else $error("bus not idle after STOP");
  a_dev_quiet_stop: assert property (
    stop |=> !dev_sda_oe [*6])
    else $error("slave drove data after STOP");

  c_start: cover property (start);
  c_stop: cover property (stop);
  c_addr_ack: cover property (scl && scl_r && rise_r == 4'h9 && dev_sda_oe);
endmodule : rtcsp_chk
